/* File: logic/brc_map.svh */
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH

// Register byte addresses
`define BRC_BUCK_ONE_STANDBY_SETPOINT 8'h10
`define BRC_BUCK_ONE_RESERVED 8'h11
`define BRC_BUCK_ONE_CONTROL_STATUS 8'h12
`define BRC_BUCK_ONE_SETPOINT_RANGE 8'h13
`define BRC_BUCK_TWO_STANDBY_SETPOINT 8'h20
`define BRC_BUCK_TWO_RESERVED 8'h21
`define BRC_BUCK_TWO_CONTROL_STATUS 8'h22
`define BRC_BUCK_TWO_SETPOINT_RANGE 8'h23

// Field positions
`define BRC_CODE_MSB 5
`define BRC_ENABLE_BIT 0
`define BRC_POWER_GOOD_BIT 1
`define BRC_FAULT_UNMASK_BIT 2
`define BRC_HIGH_RANGE_BIT 6

// Reset values
`define BRC_RST_CODE 6'h00
`define BRC_RST_ENABLE 1'b0
`define BRC_RST_UNMASK 1'b0
`define BRC_RST_RANGE 1'b0
`define BRC_RST_RD_DATA 8'h00

// Setpoint decode, in millivolts
`define BRC_ADJUST_CODE 6'h00
`define BRC_LOW_KNEE_CODE 6'h07
`define BRC_LOW_ODD_CODE 6'h22
`define BRC_LOW_MIN_MV 13'h0320
`define BRC_LOW_ODD_MV 13'h05C8
`define BRC_LOW_STEP_MV 13'h0019
`define BRC_HIGH_FIRST_MV 13'h0514
`define BRC_HIGH_STEP_MV 13'h0032
`define BRC_ADJUST_MV 13'h0000

`endif

/* File: logic/brc_pkg.sv */
package brc_pkg;

    typedef logic [5:0] brc_code_t;
    typedef logic [12:0] brc_mv_t;

    typedef enum logic [2:0] {
        BRC_SEL_NONE = 3'b000,
        BRC_SEL_STBY = 3'b001,
        BRC_SEL_RSVD = 3'b010,
        BRC_SEL_CTRL = 3'b011,
        BRC_SEL_RANGE = 3'b100
    } brc_sel_t;

endpackage : brc_pkg

/* File: logic/brc_chan.sv */
`timescale 1ns/1ps
`include "brc_map.svh"

module brc_chan (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_standby,
    input wire brc_pkg::brc_code_t i_standby_code,
    input wire brc_pkg::brc_code_t i_normal_code,
    input wire logic i_high_range,
    output brc_pkg::brc_mv_t o_setpoint_mv,
    output logic o_adjustable
);
    import brc_pkg::*;

    brc_code_t code;
    brc_mv_t code_mv;
    brc_mv_t mv_nxt;

    always_comb begin
        code = i_standby ? i_standby_code : i_normal_code;
        code_mv = {7'h00, code};
        mv_nxt = `BRC_ADJUST_MV;
        if (code == `BRC_ADJUST_CODE) begin
            mv_nxt = `BRC_ADJUST_MV;
        end else if (i_high_range) begin
            mv_nxt = 13'(`BRC_HIGH_FIRST_MV
                + (code_mv - 13'h0001) * `BRC_HIGH_STEP_MV);
        end else if (code <= `BRC_LOW_KNEE_CODE) begin
            mv_nxt = `BRC_LOW_MIN_MV;
        end else if (code == `BRC_LOW_ODD_CODE) begin
            mv_nxt = `BRC_LOW_ODD_MV;
        end else begin
            mv_nxt = 13'(`BRC_LOW_MIN_MV + (code_mv
                - {7'h00, `BRC_LOW_KNEE_CODE}) * `BRC_LOW_STEP_MV);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_setpoint_mv <= `BRC_ADJUST_MV;
            o_adjustable <= 1'b1;
        end else begin
            o_setpoint_mv <= mv_nxt;
            o_adjustable <= (code == `BRC_ADJUST_CODE);
        end
    end

endmodule : brc_chan

/* File: logic/brc_regs.sv */
// What this block does
// - Decode buck one bank at 0x10-0x13, buck two at 0x20-0x23.
// - Byte 0 bits 5:0 hold the read/write standby voltage code.
// - Byte 3 bits 5:0 hold the read/write normal voltage code.
// - Byte 2 bit 0 enables the converter when one.
// - Byte 2 bit 1 reads power good, read only.
// - Byte 2 bit 2 one leaves the voltage fault unmasked.
// - Byte 3 bit 6 zero selects low range, minimum 0.8 V.
// - Range bit one decodes both codes in high range, minimum 1.30 V.
// - Reserved bits are read only and ignore host writes.
// - Low range: codes 1-7 give 0.800 V, then 25 mV steps; 0x22 1.480 V.
// - High range: code 1 gives 1.300 V, 50 mV steps to 4.400 V.
// - Code zero selects adjustable mode in either range.
// - Buck two bank matches buck one fields and encoding.
`timescale 1ns/1ps
`include "brc_map.svh"

module brc_regs (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [1:0] i_power_good,
    input wire logic i_standby,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic [1:0] o_enable,
    output logic [1:0] o_fault_event,
    output logic [1:0] o_adjustable,
    output brc_pkg::brc_mv_t o_buck_one_setpoint_mv,
    output brc_pkg::brc_mv_t o_buck_two_setpoint_mv
);
    import brc_pkg::*;

    brc_sel_t sel;
    logic ch;
    logic [7:0] rd_data_nxt;

    brc_code_t stby_code_r [2];
    brc_code_t norm_code_r [2];
    logic [1:0] range_r;
    logic [1:0] unmask_r;
    logic [1:0] pgood_r;

    always_comb begin
        sel = BRC_SEL_NONE;
        ch = 1'b0;
        case (i_addr)
            `BRC_BUCK_ONE_STANDBY_SETPOINT: begin
                sel = BRC_SEL_STBY;
            end
            `BRC_BUCK_ONE_RESERVED: begin
                sel = BRC_SEL_RSVD;
            end
            `BRC_BUCK_ONE_CONTROL_STATUS: begin
                sel = BRC_SEL_CTRL;
            end
            `BRC_BUCK_ONE_SETPOINT_RANGE: begin
                sel = BRC_SEL_RANGE;
            end
            `BRC_BUCK_TWO_STANDBY_SETPOINT: begin
                sel = BRC_SEL_STBY;
                ch = 1'b1;
            end
            `BRC_BUCK_TWO_RESERVED: begin
                sel = BRC_SEL_RSVD;
                ch = 1'b1;
            end
            `BRC_BUCK_TWO_CONTROL_STATUS: begin
                sel = BRC_SEL_CTRL;
                ch = 1'b1;
            end
            `BRC_BUCK_TWO_SETPOINT_RANGE: begin
                sel = BRC_SEL_RANGE;
                ch = 1'b1;
            end
            default: begin
                sel = BRC_SEL_NONE;
                ch = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            for (int c = 0; c < 2; c++) begin
                stby_code_r[c] <= `BRC_RST_CODE;
            end
        end else if (i_wr_en && sel == BRC_SEL_STBY) begin
            stby_code_r[ch] <= i_wr_data[`BRC_CODE_MSB:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            for (int c = 0; c < 2; c++) begin
                norm_code_r[c] <= `BRC_RST_CODE;
            end
        end else if (i_wr_en && sel == BRC_SEL_RANGE) begin
            norm_code_r[ch] <= i_wr_data[`BRC_CODE_MSB:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            range_r <= {2{`BRC_RST_RANGE}};
        end else if (i_wr_en && sel == BRC_SEL_RANGE) begin
            range_r[ch] <= i_wr_data[`BRC_HIGH_RANGE_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_enable <= {2{`BRC_RST_ENABLE}};
        end else if (i_wr_en && sel == BRC_SEL_CTRL) begin
            o_enable[ch] <= i_wr_data[`BRC_ENABLE_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            unmask_r <= {2{`BRC_RST_UNMASK}};
        end else if (i_wr_en && sel == BRC_SEL_CTRL) begin
            unmask_r[ch] <= i_wr_data[`BRC_FAULT_UNMASK_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pgood_r <= 2'h0;
        end else begin
            pgood_r <= i_power_good;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_fault_event <= 2'h0;
        end else begin
            o_fault_event <= o_enable & ~pgood_r & unmask_r;
        end
    end

    always_comb begin
        rd_data_nxt = 8'h00;
        case (sel)
            BRC_SEL_STBY: begin
                rd_data_nxt[`BRC_CODE_MSB:0] = stby_code_r[ch];
            end
            BRC_SEL_CTRL: begin
                rd_data_nxt[`BRC_ENABLE_BIT] = o_enable[ch];
                rd_data_nxt[`BRC_POWER_GOOD_BIT] = pgood_r[ch];
                rd_data_nxt[`BRC_FAULT_UNMASK_BIT] = unmask_r[ch];
            end
            BRC_SEL_RANGE: begin
                rd_data_nxt[`BRC_CODE_MSB:0] = norm_code_r[ch];
                rd_data_nxt[`BRC_HIGH_RANGE_BIT] = range_r[ch];
            end
            default: begin
                rd_data_nxt = 8'h00;
            end
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_rd_data <= `BRC_RST_RD_DATA;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rd_data <= rd_data_nxt;
            end
        end
    end

    brc_chan u_buck_one (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_standby(i_standby),
        .i_standby_code(stby_code_r[0]),
        .i_normal_code(norm_code_r[0]),
        .i_high_range(range_r[0]),
        .o_setpoint_mv(o_buck_one_setpoint_mv),
        .o_adjustable(o_adjustable[0])
    );

    brc_chan u_buck_two (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_standby(i_standby),
        .i_standby_code(stby_code_r[1]),
        .i_normal_code(norm_code_r[1]),
        .i_high_range(range_r[1]),
        .o_setpoint_mv(o_buck_two_setpoint_mv),
        .o_adjustable(o_adjustable[1])
    );

    sequence s_wr_one_stby;
        i_wr_en && i_addr == `BRC_BUCK_ONE_STANDBY_SETPOINT;
    endsequence

    sequence s_rd_one_ctrl;
        i_rd_en && i_addr == `BRC_BUCK_ONE_CONTROL_STATUS;
    endsequence

    sequence s_low_floor_one;
        !i_standby && !range_r[0] && norm_code_r[0] != `BRC_ADJUST_CODE
            && norm_code_r[0] <= `BRC_LOW_KNEE_CODE;
    endsequence

    property p_wr_stby;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_wr_one_stby |=> stby_code_r[0] == $past(i_wr_data[5:0]);
    endproperty
    a_wr_stby: assert property (p_wr_stby)
        else $error("standby code not stored");

    property p_wr_norm;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_wr_en && i_addr == `BRC_BUCK_ONE_SETPOINT_RANGE |=>
            norm_code_r[0] == $past(i_wr_data[5:0])
            && range_r[0] == $past(i_wr_data[6]);
    endproperty
    a_wr_norm: assert property (p_wr_norm)
        else $error("normal code or range not stored");

    property p_enable;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_wr_en && i_addr == `BRC_BUCK_ONE_CONTROL_STATUS |=>
            o_enable[0] == $past(i_wr_data[0])
            && unmask_r[0] == $past(i_wr_data[2]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable or mask not stored");

    property p_pgood_read;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_rd_one_ctrl |=> o_rd_valid && o_rd_data[1] == $past(pgood_r[0]);
    endproperty
    a_pgood_read: assert property (p_pgood_read)
        else $error("power good read wrong");

    property p_fault_gate;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!o_enable[0] || !unmask_r[0] || pgood_r[0]) |=> !o_fault_event[0];
    endproperty
    a_fault_gate: assert property (p_fault_gate)
        else $error("fault raised while gated");

    property p_fault_set;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_enable[1] && !pgood_r[1] && unmask_r[1] |=> o_fault_event[1];
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("unmasked fault not raised");

    property p_ro_bits;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_rd_en && i_addr == `BRC_BUCK_TWO_RESERVED |=> o_rd_data == 8'h00;
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("reserved byte not zero");

    property p_ro_write;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_wr_en && i_addr == `BRC_BUCK_ONE_RESERVED |=>
            $stable(o_enable) && $stable(range_r) && $stable(unmask_r);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("reserved write changed state");

    property p_low_floor;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_low_floor_one |=> o_buck_one_setpoint_mv == `BRC_LOW_MIN_MV;
    endproperty
    a_low_floor: assert property (p_low_floor)
        else $error("low range floor wrong");

    property p_low_top;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_standby && !range_r[0] && norm_code_r[0] == 6'h3F |=>
            o_buck_one_setpoint_mv == 13'h0898;
    endproperty
    a_low_top: assert property (p_low_top)
        else $error("low range top wrong");

    property p_high_step;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_standby && range_r[1] && norm_code_r[1] == 6'h01 |=>
            o_buck_two_setpoint_mv == 13'h0514;
    endproperty
    a_high_step: assert property (p_high_step)
        else $error("high range first step wrong");

    property p_high_top;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_standby && range_r[1] && norm_code_r[1] == 6'h3F |=>
            o_buck_two_setpoint_mv == 13'h1130;
    endproperty
    a_high_top: assert property (p_high_top)
        else $error("high range top wrong");

    property p_adjust;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_standby && stby_code_r[0] == `BRC_ADJUST_CODE |=>
            o_adjustable[0] && o_buck_one_setpoint_mv == `BRC_ADJUST_MV;
    endproperty
    a_adjust: assert property (p_adjust)
        else $error("adjustable mode not flagged");

    property p_standby_sel;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_standby && norm_code_r[0] != `BRC_ADJUST_CODE |=>
            !o_adjustable[0];
    endproperty
    a_standby_sel: assert property (p_standby_sel)
        else $error("normal code not applied");

    property p_bank_two;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_wr_en && i_addr == `BRC_BUCK_TWO_STANDBY_SETPOINT |=>
            stby_code_r[1] == $past(i_wr_data[5:0]) && $stable(stby_code_r[0]);
    endproperty
    a_bank_two: assert property (p_bank_two)
        else $error("second bank write misrouted");

    property p_unmapped;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_rd_en && i_addr == 8'h14 |=> o_rd_valid ##0 o_rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

endmodule : brc_regs

/* File: bench/brc_host_model.sv */
`timescale 1ns/1ps

module brc_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    logic [7:0] rd_byte;
    logic rd_seen;

    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end

    // One strobe cycle; released lines show the inverse, not the old value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_wr_en = 1'b1;
        o_addr = a;
        o_wr_data = d;
        @(negedge i_core_clk);
        o_wr_en = 1'b0;
        o_addr = ~a;
        o_wr_data = ~d;
    endtask : wr

    // Valid stands one cycle after the strobe edge; taken before release
    task automatic rd(input logic [7:0] a);
        @(negedge i_core_clk);
        o_rd_en = 1'b1;
        o_addr = a;
        @(negedge i_core_clk);
        rd_byte = i_rd_data;
        rd_seen = i_rd_valid;
        o_rd_en = 1'b0;
        o_addr = ~a;
    endtask : rd
endmodule : brc_host_model

/* File: bench/buck_regulator_control_regs_tb.sv */
`timescale 1ns/1ps

module buck_regulator_control_regs_tb;
    import brc_pkg::*;
    logic i_core_clk, i_rst_n, wr_en, rd_en, rd_valid, standby;
    logic [7:0] addr, wr_data, rd_data;
    logic [1:0] power_good, enable, fault_event, adjustable;
    brc_mv_t sp_one, sp_two;
    logic [15:0] lfsr;
    logic [7:0] sh [0:1][0:3];
    int fail_count, n_checks, cycles, n, k;
    localparam logic [7:0] WMASK [4] = '{8'h3F, 8'h00, 8'h05, 8'h7F};
    localparam logic [7:0] BAD [7] =
        '{8'h00, 8'h11, 8'h14, 8'h1F, 8'h21, 8'h30, 8'hFF};
    localparam logic [7:0] CORNER [3] = '{8'h3F, 8'h01, 8'h22};

    brc_regs u_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data),
        .i_power_good(power_good), .i_standby(standby),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_enable(enable),
        .o_fault_event(fault_event), .o_adjustable(adjustable),
        .o_buck_one_setpoint_mv(sp_one), .o_buck_two_setpoint_mv(sp_two)
    );

    brc_host_model u_host (
        .i_core_clk(i_core_clk), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wr_data(wr_data)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    function automatic logic [7:0] addr_of(input int ch, input int i);
        return {2'b00, ch[0] ? 2'b10 : 2'b01, 2'b00, i[1:0]};
    endfunction : addr_of

    function automatic logic [7:0] exp_rd(input int ch, input int i);
        if (i == 2)
            return sh[ch][2] | {6'h00, power_good[ch], 1'b0};
        return sh[ch][i];
    endfunction : exp_rd

    function automatic brc_mv_t exp_mv(input logic [5:0] c, input logic h);
        if (c == 6'h00)
            return 13'h0000;
        if (h)
            return 13'h0514 + 13'h0032 * 13'(c - 6'h01);
        if (c <= 6'h07)
            return 13'h0320;
        if (c == 6'h22)
            return 13'h05C8;
        return 13'h0320 + 13'h0019 * 13'(c - 6'h07);
    endfunction : exp_mv

    task automatic bump();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    endtask : bump

    task automatic fail(input logic [15:0] got, input logic [15:0] exp);
        fail_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    endtask : fail

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
            fail({8'h00, got}, {8'h00, exp});
    endtask : chk_byte

    task automatic chk_mv(input brc_mv_t got, input brc_mv_t exp);
        n_checks++;
        if (got !== exp)
            fail({3'b000, got}, {3'b000, exp});
    endtask : chk_mv

    task automatic chk_bit2(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp)
            fail({14'h0000, got}, {14'h0000, exp});
    endtask : chk_bit2

    task automatic wr_reg(input int ch, input int i, input logic [7:0] d);
        u_host.wr(addr_of(ch, i), d);
        sh[ch][i] = d & WMASK[i];
    endtask : wr_reg

    task automatic rd_chk(input int ch, input int i);
        u_host.rd(addr_of(ch, i));
        chk_byte(u_host.rd_byte, exp_rd(ch, i));
        chk_bit2({1'b0, u_host.rd_seen}, 2'b01);
    endtask : rd_chk

    task automatic chk_sp();
        logic [5:0] c;
        for (int j = 0; j < 2; j++) begin
            c = standby ? sh[j][0][5:0] : sh[j][3][5:0];
            chk_mv(j ? sp_two : sp_one, exp_mv(c, sh[j][3][6]));
            chk_bit2({1'b0, adjustable[j]}, {1'b0, c == 6'h00});
        end
    endtask : chk_sp

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // Hang guard, well above the expected run length
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        i_rst_n = 1'b0;
        standby = 1'b0;
        power_good = 2'b00;
        lfsr = 16'hEEBA;
        fail_count = 0;
        n_checks = 0;
        cycles = 0;
        for (n = 0; n < 8; n++)
            sh[n / 4][n % 4] = 8'h00;
        repeat (12) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        chk_bit2(adjustable, 2'b11);
        chk_mv(sp_one, 13'h0000);
        for (n = 0; n < 8; n++)
            rd_chk(n / 4, n % 4);
        power_good = 2'b11;
        for (n = 0; n < 200; n++) begin
            bump();
            wr_reg(lfsr[8], lfsr[10:9], lfsr[7:0]);
            rd_chk(lfsr[8], lfsr[10:9]);
            chk_bit2(enable, {sh[1][2][0], sh[0][2][0]});
        end
        for (n = 0; n < 7; n++) begin
            u_host.wr(BAD[n], 8'hFF);
            u_host.rd(BAD[n]);
            chk_byte(u_host.rd_byte, 8'h00);
        end
        for (n = 0; n < 8; n++)
            rd_chk(n / 4, n % 4);
        for (n = 0; n < 128; n++) begin
            bump();
            wr_reg(0, 3, {1'b0, n[6], n[5:0]});
            wr_reg(0, 0, {2'b00, ~n[5:0]});
            wr_reg(1, 0, {2'b00, n[5:0]});
            wr_reg(1, 3, {1'b1, n[6], lfsr[5:0]});
            standby = lfsr[7];
            repeat (3) @(negedge i_core_clk);
            chk_sp();
        end
        // Range end points and the odd entry with standby low
        standby = 1'b0;
        for (n = 0; n < 3; n++) begin
            wr_reg(0, 3, CORNER[n]);
            wr_reg(1, 3, CORNER[n] | 8'h40);
            repeat (3) @(negedge i_core_clk);
            chk_sp();
        end
        // Standby code zero gives adjustable mode
        standby = 1'b1;
        wr_reg(0, 0, 8'h00);
        repeat (3) @(negedge i_core_clk);
        chk_sp();
        for (n = 0; n < 48; n++) begin
            bump();
            wr_reg(0, 2, lfsr[7:0]);
            wr_reg(1, 2, lfsr[15:8]);
            bump();
            power_good = lfsr[1:0];
            repeat (3) @(negedge i_core_clk);
            for (k = 0; k < 2; k++)
                chk_bit2({1'b0, fault_event[k]}, {1'b0, sh[k][2][0]
                    & ~power_good[k] & sh[k][2][2]});
            rd_chk(0, 2);
            rd_chk(1, 2);
        end
        // Reset in mid-run clears every writable field; power good reads its input again
        @(negedge i_core_clk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        for (n = 0; n < 8; n++)
            sh[n / 4][n % 4] = 8'h00;
        chk_bit2(enable, 2'b00);
        chk_bit2(adjustable, 2'b11);
        for (n = 0; n < 8; n++)
            rd_chk(n / 4, n % 4);
        end_sim();
    end
endmodule : buck_regulator_control_regs_tb
